/* File: rtl/tlc_pkg.sv */
// Purpose: constants, types and the command map of the trigger and logging control
// Assumes: one 40 MHz clock, commands arrive already decoded from the host text
// Notes: APB register map, one aligned word per register
//
// How it works
// - accepted arm command discards any reading held in reading memory.
// - fetch copies the held reading to the output buffer.
// - abort returns the trigger system to idle from armed or waiting.
// - with bus trigger source, measure only after a later trigger command or a rising edge on the trigger pin.
// - continuous on measures repeatedly, keeps reading memory fresh, fetch gets latest.
// - continuous off measures only through the arm-and-trigger sequence.
// - arm or read query forces continuous setting off.
// - continuous accepts 0 or 1, defaults to 1, query returns it.
// - logging state 1 starts a session at once, 0 stops it.
// - logging indicator is high exactly while a session is active.
// - logging state defaults to 0 and its query returns the status.
// - session ends by itself when complete or log memory is full.
// - new session appends after records already stored.
// - while recording, every setting command except the logging state is refused.
// - erase command deletes every stored log record.
// - load command resets the readback index to the first record.
// - each log data query returns the indexed record and advances; then end marker.
// - with continuous off, measurement begins only once the trigger condition follows the arm command.
package tlc_pkg;
  localparam int unsigned tlc_addr_w = 8;
  localparam int unsigned tlc_data_w = 32;

  // register byte addresses
  localparam logic [7:0] tlc_cmd_off = 8'h00;
  localparam logic [7:0] tlc_cfg_off = 8'h04;
  localparam logic [7:0] tlc_stat_off = 8'h08;
  localparam logic [7:0] tlc_resp_off = 8'h0c;
  localparam logic [7:0] tlc_logcnt_off = 8'h10;
  localparam logic [7:0] tlc_session_off = 8'h14;

  // command codes written to the command register
  typedef enum logic [3:0] {
    tlc_c_none = 4'h0,
    tlc_c_arm = 4'h1,
    tlc_c_read = 4'h2,
    tlc_c_fetch = 4'h3,
    tlc_c_abort = 4'h4,
    tlc_c_trg = 4'h5,
    tlc_c_cont_off = 4'h6,
    tlc_c_cont_on = 4'h7,
    tlc_c_log_off = 4'h8,
    tlc_c_log_on = 4'h9,
    tlc_c_erase = 4'ha,
    tlc_c_load = 4'hb,
    tlc_c_logdata = 4'hc,
    tlc_c_src_imm = 4'hd,
    tlc_c_src_bus = 4'he
  } tlc_cmd_e;

  // response kinds in the response register
  typedef enum logic [1:0] {
    tlc_r_none = 2'h0,
    tlc_r_data = 2'h1,
    tlc_r_end = 2'h2,
    tlc_r_error = 2'h3
  } tlc_resp_e;

  typedef enum logic [1:0] {
    tlc_t_idle = 2'b00,
    tlc_t_wait = 2'b01,
    tlc_t_meas = 2'b11
  } tlc_trig_e;

  // status bit positions
  localparam int unsigned tlc_st_cont = 0;
  localparam int unsigned tlc_st_log = 1;
  localparam int unsigned tlc_st_valid = 2;
  localparam int unsigned tlc_st_srcbus = 3;
  localparam int unsigned tlc_st_trig_lo = 4;
  localparam int unsigned tlc_st_refused = 6;
  localparam int unsigned tlc_st_err = 7;

  localparam logic tlc_cont_rst = 1'b1;
  localparam logic tlc_log_rst = 1'b0;

  typedef struct packed {
    logic [1:0] kind;
    logic [29:0] value;
  } tlc_resp_s;
endpackage

/* File: rtl/tlc_log_mem.sv */
// Purpose: log record store with registered read data
// Assumes: at most one write and one read per cycle
// Notes: read data appear one cycle after the read request
`timescale 1ns/1ps
module tlc_log_mem #(
  parameter int unsigned depth = 16,
  parameter int unsigned width = 30,
  parameter int unsigned aw = 4
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [aw-1:0] wr_addr,
  input wire logic [width-1:0] wr_data,
  input wire logic [aw-1:0] rd_addr,
  output logic [width-1:0] rd_data
);
  logic [width-1:0] mem [depth];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

/* File: rtl/tlc_sync.sv */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input is asynchronous to clk
// Notes: output changes once stages two and three agree
`timescale 1ns/1ps
module tlc_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic [2:0] sh_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_reg <= 3'h0;
      dout <= 1'b0;
    end else begin
      sh_reg <= {sh_reg[1:0], din};
      if (sh_reg[1] == sh_reg[2]) begin
        dout <= sh_reg[2];
      end
    end
  end
endmodule

/* File: rtl/tlc_top.sv */
// Purpose: trigger state, continuous mode, reading memory and logging session control
// Assumes: host commands arrive as codes over APB; measurement engine answers meas_done
// Notes: log memory depth and the reset value of the session length are parameters
`timescale 1ns/1ps
module tlc_top #(
  parameter int unsigned log_depth = 16,
  parameter int unsigned log_aw = 4,
  parameter int unsigned session_len_default = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic meas_done,
  input wire logic [29:0] meas_value,
  input wire logic ext_trig,
  output logic meas_start,
  output logic log_indicator
);
  localparam logic [log_aw:0] full_cnt = (log_aw + 1)'(log_depth);

  typedef struct packed {
    tlc_pkg::tlc_trig_e trig;
    logic cont;
    logic src_bus;
    logic trg_pend;
    logic valid;
    logic [29:0] reading;
    logic log_on;
    logic [log_aw:0] log_cnt;
    logic [log_aw:0] rd_idx;
    logic [15:0] sess_len;
    logic [15:0] sess_cnt;
    logic rd_pend;
    logic read_q;
    logic refused;
    logic err;
    tlc_pkg::tlc_resp_s resp;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic meas_start;
    logic log_ind;
  } tlc_state_s;

  tlc_state_s st_reg;
  tlc_state_s st_next;
  logic trig_sync;
  logic trig_q_reg;
  logic [29:0] mem_rd;
  logic mem_we;
  logic [log_aw-1:0] mem_wa;
  logic [log_aw-1:0] mem_ra;

  tlc_sync u_sync (
    .clk(clk),
    .rst(rst),
    .din(ext_trig),
    .dout(trig_sync)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_q_reg <= 1'b0;
    end else begin
      trig_q_reg <= trig_sync;
    end
  end

  // log records are readings taken while the session runs; none past its length
  assign mem_we = st_reg.log_on && meas_done && (st_reg.log_cnt < full_cnt) &&
    (st_reg.sess_cnt < st_reg.sess_len);
  assign mem_wa = st_reg.log_cnt[log_aw-1:0];
  assign mem_ra = st_reg.rd_idx[log_aw-1:0];

  tlc_log_mem #(
    .depth(log_depth),
    .width(30),
    .aw(log_aw)
  ) u_mem (
    .clk(clk),
    .wr_en(mem_we),
    .wr_addr(mem_wa),
    .wr_data(meas_value),
    .rd_addr(mem_ra),
    .rd_data(mem_rd)
  );

  logic setup;
  logic acc;
  assign setup = psel && !penable && !st_reg.pready;

  always_comb begin
    logic [3:0] code;
    logic is_setting;
    logic trig_edge;
    st_next = st_reg;
    code = pwdata[3:0];
    is_setting = 1'b0;
    trig_edge = trig_sync && !trig_q_reg;
    acc = 1'b0;
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;
    st_next.meas_start = 1'b0;

    // no wait state: answer in the cycle after setup
    if (setup) begin
      acc = 1'b1;
      st_next.pready = 1'b1;
    end

    // measurement engine results
    if (meas_done && st_reg.trig == tlc_pkg::tlc_t_meas) begin
      st_next.reading = meas_value;
      st_next.valid = 1'b1;
      st_next.trig = tlc_pkg::tlc_t_idle;
      if (st_reg.read_q) begin
        st_next.resp = '{kind: tlc_pkg::tlc_r_data, value: meas_value};
        st_next.read_q = 1'b0;
      end
    end
    if (meas_done && st_reg.cont && st_reg.trig == tlc_pkg::tlc_t_idle) begin
      st_next.reading = meas_value;
      st_next.valid = 1'b1;
    end
    // free run keeps the engine busy; log sessions also record in free run
    if (st_reg.cont && st_reg.trig == tlc_pkg::tlc_t_idle) begin
      st_next.meas_start = 1'b1;
    end

    // waiting: fire on the selected condition only
    if (st_reg.trig == tlc_pkg::tlc_t_wait) begin
      if (!st_reg.src_bus || st_reg.trg_pend || (st_reg.src_bus && trig_edge)) begin
        st_next.trig = tlc_pkg::tlc_t_meas;
        st_next.meas_start = 1'b1;
        st_next.trg_pend = 1'b0;
      end
    end

    // logging session progress
    if (mem_we) begin
      st_next.log_cnt = st_reg.log_cnt + 1'b1;
      st_next.sess_cnt = st_reg.sess_cnt + 16'h1;
    end
    if (st_reg.log_on && ((st_reg.log_cnt >= full_cnt) || (st_reg.sess_cnt >= st_reg.sess_len))) begin
      st_next.log_on = 1'b0;
    end

    // log data read answers one cycle after the memory read
    if (st_reg.rd_pend) begin
      st_next.rd_pend = 1'b0;
      st_next.resp = '{kind: tlc_pkg::tlc_r_data, value: mem_rd};
    end

    if (acc && pwrite) begin
      unique case (paddr)
        tlc_pkg::tlc_cmd_off: begin
          is_setting = code inside {tlc_pkg::tlc_c_arm, tlc_pkg::tlc_c_read, tlc_pkg::tlc_c_abort,
            tlc_pkg::tlc_c_cont_off, tlc_pkg::tlc_c_cont_on, tlc_pkg::tlc_c_erase,
            tlc_pkg::tlc_c_src_imm, tlc_pkg::tlc_c_src_bus, tlc_pkg::tlc_c_trg};
          if (st_reg.log_on && is_setting) begin
            st_next.refused = 1'b1;
          end else begin
            unique case (tlc_pkg::tlc_cmd_e'(code))
              tlc_pkg::tlc_c_arm, tlc_pkg::tlc_c_read: begin
                st_next.valid = 1'b0;
                st_next.cont = 1'b0;
                st_next.trig = tlc_pkg::tlc_t_wait;
                st_next.trg_pend = 1'b0;
                st_next.read_q = (code == tlc_pkg::tlc_c_read);
                st_next.resp = '{kind: tlc_pkg::tlc_r_none, value: 30'h0};
              end
              tlc_pkg::tlc_c_fetch: begin
                if (st_reg.valid) begin
                  st_next.resp = '{kind: tlc_pkg::tlc_r_data, value: st_reg.reading};
                end else begin
                  st_next.resp = '{kind: tlc_pkg::tlc_r_error, value: 30'h0};
                  st_next.err = 1'b1;
                end
              end
              tlc_pkg::tlc_c_abort: begin
                st_next.trig = tlc_pkg::tlc_t_idle;
                st_next.trg_pend = 1'b0;
                st_next.read_q = 1'b0;
              end
              tlc_pkg::tlc_c_trg: begin
                if (st_reg.src_bus && st_reg.trig == tlc_pkg::tlc_t_wait) begin
                  st_next.trg_pend = 1'b1;
                end
              end
              tlc_pkg::tlc_c_cont_off: st_next.cont = 1'b0;
              tlc_pkg::tlc_c_cont_on: st_next.cont = 1'b1;
              tlc_pkg::tlc_c_log_on: begin
                // a full log cannot reopen a session
                st_next.log_on = (st_reg.log_cnt < full_cnt);
                st_next.sess_cnt = 16'h0;
              end
              tlc_pkg::tlc_c_log_off: st_next.log_on = 1'b0;
              tlc_pkg::tlc_c_erase: begin
                st_next.log_cnt = '0;
                st_next.rd_idx = '0;
              end
              tlc_pkg::tlc_c_load: st_next.rd_idx = '0;
              tlc_pkg::tlc_c_logdata: begin
                if (st_reg.rd_idx < st_reg.log_cnt) begin
                  st_next.rd_pend = 1'b1;
                  st_next.rd_idx = st_reg.rd_idx + 1'b1;
                end else begin
                  st_next.resp = '{kind: tlc_pkg::tlc_r_end, value: 30'h0};
                end
              end
              tlc_pkg::tlc_c_src_imm: st_next.src_bus = 1'b0;
              tlc_pkg::tlc_c_src_bus: st_next.src_bus = 1'b1;
              default: st_next.err = 1'b1;
            endcase
          end
        end
        tlc_pkg::tlc_session_off: begin
          if (st_reg.log_on) begin
            st_next.refused = 1'b1;
          end else begin
            st_next.sess_len = pwdata[15:0];
          end
        end
        tlc_pkg::tlc_stat_off: begin
          // write one clears the sticky flags; only writes set them, so no new event can land the same cycle
          if (pwdata[tlc_pkg::tlc_st_refused]) st_next.refused = 1'b0;
          if (pwdata[tlc_pkg::tlc_st_err]) st_next.err = 1'b0;
        end
        default: st_next.pslverr = 1'b1;
      endcase
    end else if (acc) begin
      st_next.prdata = 32'h0;
      unique case (paddr)
        tlc_pkg::tlc_cmd_off: st_next.prdata = 32'h0;
        tlc_pkg::tlc_cfg_off: st_next.prdata = {30'h0, st_reg.log_on, st_reg.cont};
        tlc_pkg::tlc_stat_off: begin
          st_next.prdata[tlc_pkg::tlc_st_cont] = st_reg.cont;
          st_next.prdata[tlc_pkg::tlc_st_log] = st_reg.log_on;
          st_next.prdata[tlc_pkg::tlc_st_valid] = st_reg.valid;
          st_next.prdata[tlc_pkg::tlc_st_srcbus] = st_reg.src_bus;
          st_next.prdata[tlc_pkg::tlc_st_trig_lo +: 2] = st_reg.trig;
          st_next.prdata[tlc_pkg::tlc_st_refused] = st_reg.refused;
          st_next.prdata[tlc_pkg::tlc_st_err] = st_reg.err;
        end
        tlc_pkg::tlc_resp_off: begin
          st_next.prdata = st_reg.resp;
          st_next.resp = '{kind: tlc_pkg::tlc_r_none, value: 30'h0};
        end
        tlc_pkg::tlc_logcnt_off: st_next.prdata = 32'(st_reg.log_cnt);
        tlc_pkg::tlc_session_off: st_next.prdata = {16'h0, st_reg.sess_len};
        default: st_next.pslverr = 1'b1;
      endcase
    end
    st_next.log_ind = st_next.log_on;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.cont <= tlc_pkg::tlc_cont_rst;
      st_reg.log_on <= tlc_pkg::tlc_log_rst;
      st_reg.sess_len <= 16'(session_len_default);
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign meas_start = st_reg.meas_start;
  assign log_indicator = st_reg.log_ind;

  // edge of the synchronised pin, as the trigger logic sees it
  logic trig_edge_w;
  assign trig_edge_w = trig_sync && !trig_q_reg;

  property arm_clears_p;
    @(posedge clk) disable iff (rst)
      (acc && pwrite && paddr == tlc_pkg::tlc_cmd_off && !st_reg.log_on &&
       pwdata[3:0] == tlc_pkg::tlc_c_arm) |=> (!st_reg.valid && !st_reg.cont);
  endproperty
  arm_clears_a: assert property (arm_clears_p) else $error("arm left reading or continuous set");

  sequence wait_fire_s;
    st_reg.trig == tlc_pkg::tlc_t_wait && !st_reg.src_bus;
  endsequence
  imm_fire_a: assert property (@(posedge clk) disable iff (rst)
    wait_fire_s |=> (st_reg.meas_start && st_reg.trig == tlc_pkg::tlc_t_meas))
    else $error("immediate source did not fire");

  bus_hold_a: assert property (@(posedge clk) disable iff (rst)
    (st_reg.trig == tlc_pkg::tlc_t_wait && st_reg.src_bus && !st_reg.trg_pend && !trig_edge_w)
    |=> st_reg.trig != tlc_pkg::tlc_t_meas)
    else $error("bus source measured without trigger");

  trg_ignore_a: assert property (@(posedge clk) disable iff (rst)
    (acc && pwrite && paddr == tlc_pkg::tlc_cmd_off && pwdata[3:0] == tlc_pkg::tlc_c_trg && !st_reg.src_bus)
    |=> !st_reg.trg_pend)
    else $error("trigger command taken with immediate source");

  abort_idle_a: assert property (@(posedge clk) disable iff (rst)
    (acc && pwrite && paddr == tlc_pkg::tlc_cmd_off && !st_reg.log_on &&
     pwdata[3:0] == tlc_pkg::tlc_c_abort) |=> st_reg.trig == tlc_pkg::tlc_t_idle)
    else $error("abort did not idle");

  fetch_empty_a: assert property (@(posedge clk) disable iff (rst)
    (acc && pwrite && paddr == tlc_pkg::tlc_cmd_off && pwdata[3:0] == tlc_pkg::tlc_c_fetch && !st_reg.valid)
    |=> st_reg.resp.kind == tlc_pkg::tlc_r_error)
    else $error("fetch without reading not an error");

  log_ind_a: assert property (@(posedge clk) disable iff (rst)
    (acc && pwrite && paddr == tlc_pkg::tlc_cmd_off && pwdata[3:0] == tlc_pkg::tlc_c_log_off)
    |=> !log_indicator)
    else $error("indicator still on after logging stopped");

  full_stop_a: assert property (@(posedge clk) disable iff (rst)
    (st_reg.log_on && st_reg.log_cnt >= full_cnt) |=> !st_reg.log_on)
    else $error("full log did not stop session");

  // a transfer in the same cycle may legally restart the session
  sess_stop_a: assert property (@(posedge clk) disable iff (rst)
    (st_reg.log_on && st_reg.sess_cnt >= st_reg.sess_len && !acc) |=> !st_reg.log_on)
    else $error("completed session did not stop");

  refuse_a: assert property (@(posedge clk) disable iff (rst)
    (st_reg.log_on && acc && pwrite && paddr == tlc_pkg::tlc_cmd_off &&
     pwdata[3:0] == tlc_pkg::tlc_c_cont_on) |=> $stable(st_reg.cont))
    else $error("setting changed while recording");

  refuse_len_a: assert property (@(posedge clk) disable iff (rst)
    (st_reg.log_on && acc && pwrite && paddr == tlc_pkg::tlc_session_off) |=> $stable(st_reg.sess_len))
    else $error("session length changed while recording");

  load_a: assert property (@(posedge clk) disable iff (rst)
    (acc && pwrite && paddr == tlc_pkg::tlc_cmd_off && pwdata[3:0] == tlc_pkg::tlc_c_load)
    |=> st_reg.rd_idx == '0)
    else $error("load did not reset index");
endmodule

/* File: tb/tlc_meas_model.sv */
// Purpose: measurement engine stand-in on the far side of tlc_top
// Assumes: one clock, a request is seen on meas_start while the engine is free
// Notes: slow stretches each measurement from 2 to 20 cycles
`timescale 1ns/1ps
module tlc_meas_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic meas_start,
  input wire logic [29:0] value,
  input wire logic slow,
  output logic meas_done,
  output logic [29:0] meas_value
);
  int cnt;

  // result bus toggles when not valid so a stale value is never mistaken for data
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      meas_done <= 1'b0;
      meas_value <= 30'h0;
    end else if (meas_done) begin
      meas_done <= 1'b0;
      meas_value <= ~meas_value;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      meas_done <= (cnt == 1);
      meas_value <= (cnt == 1) ? value : ~meas_value;
    end else begin
      cnt <= meas_start ? (slow ? 20 : 2) : 0;
      meas_value <= ~meas_value;
    end
  end
endmodule

/* File: tb/tlc_top_tb_top.sv */
// Purpose: self-checking bench of the trigger and logging control
// Assumes: apb master tasks; measurement engine model on the far side
// Notes: session length shortened to 3 records by a register write
`timescale 1ns/1ps
module tlc_top_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic meas_done;
  logic [29:0] meas_value;
  logic ext_trig = 1'b0;
  logic meas_start;
  logic log_indicator;
  logic [29:0] mval = 30'h0;
  logic slow = 1'b0;
  logic [31:0] r;
  logic err;
  logic [29:0] v1;
  logic [29:0] v2;
  logic [29:0] logq[$];
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;

  always #12.5 clk = ~clk;

  tlc_top tlc_top_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_done(meas_done), .meas_value(meas_value), .ext_trig(ext_trig),
    .meas_start(meas_start), .log_indicator(log_indicator));

  tlc_meas_model tlc_meas_model_i (.clk(clk), .rst(rst), .meas_start(meas_start),
    .value(mval), .slow(slow), .meas_done(meas_done), .meas_value(meas_value));

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // values read right after an edge are the ones the design sampled there
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input tlc_pkg::tlc_cmd_e c);
    apb(1'b1, tlc_pkg::tlc_cmd_off, {28'h0, c});
  endtask

  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int k;
    k = 0;
    do begin
      apb(1'b0, a, 32'h0);
      k++;
    end while ((r & m) !== v && k < 200);
    if ((r & m) !== v) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, r & m, v);
    end
  endtask

  task automatic get_resp();
    int k;
    k = 0;
    do begin
      apb(1'b0, tlc_pkg::tlc_resp_off, 32'h0);
      k++;
    end while (r[31:30] === 2'b00 && k < 100);
  endtask

  task automatic log_session(input logic [29:0] v, input int n);
    mval <= v;
    cmd(tlc_pkg::tlc_c_log_on);
    poll(tlc_pkg::tlc_cfg_off, 32'h2, 32'h0);
    chk(r & 32'h2, 32'h0);
    for (int i = 0; i < n; i++) begin
      logq.push_back(v);
    end
  endtask

  initial begin
    void'($urandom(32'h84a4));
    v1 = 30'($urandom);
    v2 = 30'($urandom);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, tlc_pkg::tlc_cfg_off, 32'h0);
    chk(r, 32'h1);
    chk(log_indicator, 1'b0);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    $display("test reset done");
    mval <= v1;
    cmd(tlc_pkg::tlc_c_cont_off);
    poll(tlc_pkg::tlc_stat_off, 32'h30, 32'h0);
    cmd(tlc_pkg::tlc_c_src_bus);
    cmd(tlc_pkg::tlc_c_arm);
    apb(1'b0, tlc_pkg::tlc_cfg_off, 32'h0);
    chk(r & 32'h1, 32'h0);
    repeat (40) @(posedge clk);
    apb(1'b0, tlc_pkg::tlc_stat_off, 32'h0);
    chk(r & 32'h34, 32'h10);
    cmd(tlc_pkg::tlc_c_fetch);
    get_resp();
    chk(r[31:30], tlc_pkg::tlc_r_error);
    cmd(tlc_pkg::tlc_c_trg);
    poll(tlc_pkg::tlc_stat_off, 32'h34, 32'h04);
    chk(r & 32'h34, 32'h04);
    cmd(tlc_pkg::tlc_c_fetch);
    get_resp();
    chk(r, {2'b01, v1});
    cmd(tlc_pkg::tlc_c_arm);
    apb(1'b0, tlc_pkg::tlc_stat_off, 32'h0);
    chk(r & 32'h34, 32'h10);
    cmd(tlc_pkg::tlc_c_abort);
    apb(1'b0, tlc_pkg::tlc_stat_off, 32'h0);
    chk(r & 32'h30, 32'h0);
    cmd(tlc_pkg::tlc_c_arm);
    ext_trig <= 1'b1;
    poll(tlc_pkg::tlc_stat_off, 32'h34, 32'h04);
    chk(r & 32'h34, 32'h04);
    ext_trig <= 1'b0;
    $display("test trigger done");
    cmd(tlc_pkg::tlc_c_src_imm);
    cmd(tlc_pkg::tlc_c_trg);
    slow <= 1'b1;
    mval <= v2;
    cmd(tlc_pkg::tlc_c_cont_on);
    cmd(tlc_pkg::tlc_c_read);
    apb(1'b0, tlc_pkg::tlc_cfg_off, 32'h0);
    chk(r & 32'h1, 32'h0);
    get_resp();
    chk(r, {2'b01, v2});
    slow <= 1'b0;
    cmd(tlc_pkg::tlc_c_cont_on);
    for (int i = 0; i < 2; i++) begin
      mval <= i ? v2 : v1;
      repeat (12) @(posedge clk);
      cmd(tlc_pkg::tlc_c_fetch);
      get_resp();
      chk(r, {2'b01, (i ? v2 : v1)});
    end
    $display("test continuous done");
    slow <= 1'b1;
    cmd(tlc_pkg::tlc_c_log_on);
    cmd(tlc_pkg::tlc_c_log_off);
    @(negedge clk);
    chk(log_indicator, 1'b0);
    cmd(tlc_pkg::tlc_c_erase);
    apb(1'b0, tlc_pkg::tlc_logcnt_off, 32'h0);
    chk(r, 32'h0);
    cmd(tlc_pkg::tlc_c_logdata);
    get_resp();
    chk(r[31:30], tlc_pkg::tlc_r_end);
    apb(1'b1, tlc_pkg::tlc_session_off, 32'h3);
    mval <= v1;
    cmd(tlc_pkg::tlc_c_log_on);
    apb(1'b0, tlc_pkg::tlc_cfg_off, 32'h0);
    chk(r & 32'h2, 32'h2);
    @(negedge clk);
    chk(log_indicator, 1'b1);
    cmd(tlc_pkg::tlc_c_cont_off);
    apb(1'b1, tlc_pkg::tlc_session_off, 32'h5);
    apb(1'b0, tlc_pkg::tlc_session_off, 32'h0);
    chk(r, 32'h3);
    apb(1'b0, tlc_pkg::tlc_stat_off, 32'h0);
    chk(r & 32'h41, 32'h41);
    apb(1'b1, tlc_pkg::tlc_stat_off, 32'h40);
    poll(tlc_pkg::tlc_cfg_off, 32'h2, 32'h0);
    chk(r & 32'h2, 32'h0);
    repeat (3) logq.push_back(v1);
    @(negedge clk);
    chk(log_indicator, 1'b0);
    log_session(v2, 3);
    apb(1'b0, tlc_pkg::tlc_logcnt_off, 32'h0);
    chk(r, logq.size());
    $display("test logging done");
    cmd(tlc_pkg::tlc_c_load);
    foreach (logq[i]) begin
      cmd(tlc_pkg::tlc_c_logdata);
      get_resp();
      chk(r, {2'b01, logq[i]});
    end
    cmd(tlc_pkg::tlc_c_logdata);
    get_resp();
    chk(r[31:30], tlc_pkg::tlc_r_end);
    $display("test readback done");
    apb(1'b1, tlc_pkg::tlc_session_off, 32'hc);
    log_session(v1, 10);
    apb(1'b0, tlc_pkg::tlc_logcnt_off, 32'h0);
    chk(r, 32'h10);
    $display("test full done");
    end_of_test();
  end
endmodule
